// file: rtl/serial_gpio_consts.svh
// Register offsets, field positions, reset values and timing counts for the serial GPIO controller
`ifndef SERIAL_GPIO_CONSTS_SVH
`define SERIAL_GPIO_CONSTS_SVH

// Byte offsets; replicated registers take four consecutive words
`define OFS_INPUT_DATA      8'h00
`define OFS_INT_POLARITY    8'h10
`define OFS_PORT_ENABLE     8'hA4
`define OFS_GENERAL_CONFIG  8'hA8
`define OFS_SHIFT_CLOCK     8'hAC
`define OFS_STICKY_INT      8'hB0
`define OFS_OUTPUT_VALUE    8'hC0
`define OFS_OUTPUT_MODE     8'hD0

// General configuration fields
`define CFG_BLINK_B_LSB     20
`define CFG_BLINK_A_LSB     18
`define CFG_BLINK_RESET     17
`define CFG_IRQ_EN_LSB      13
`define CFG_GAP_DISABLE     12
`define CFG_GAP_LSB         7
`define CFG_SINGLE_SHOT     6
`define CFG_AUTO_REPEAT     5
`define CFG_LOAD_POLARITY   4
`define CFG_WIDTH_LSB       2
`define CFG_REVERSE_OUT     1
`define CFG_REVERSE_IN      0
`define CFG_WIDTH           22

// Reset values
`define RST_CONFIG          22'h000000
`define RST_DIVIDER         12'h000
`define RST_WORD            32'h00000000
`define RST_VECTOR          128'h0

// Timing
`define CLOCK_PERIOD_PS     8000
`define BLINK_HALF_PS       64'd25000000000
`define GAP_STEP_PS         64'd1050000000
`define BLINK_TICK_CYCLES   (`BLINK_HALF_PS / `CLOCK_PERIOD_PS)
`define GAP_STEP_CYCLES     (`GAP_STEP_PS / `CLOCK_PERIOD_PS)

`endif

// file: rtl/serial_gpio_pkg.sv
// Types shared by the serial GPIO controller
package serial_gpio_pkg;
  typedef enum logic [3:0] {
    STATE_IDLE  = 4'b0001,
    STATE_SHIFT = 4'b0010,
    STATE_LOAD  = 4'b0100,
    STATE_GAP   = 4'b1000
  } engine_state_t;
  typedef logic [127:0] gpio_vector_t;
endpackage

// file: rtl/serial_gpio_shift_controller.sv
// Serial GPIO shift controller with AHB-Lite register slave
// Notes on behaviour
// - Pattern B select codes 0..2 give about 20, 10, 5 Hz; code 3 burst toggle.
// - In burst toggle, pattern B flips once per finished burst.
// - Pattern A select codes 0..3 give about 20, 10, 5, 2.5 Hz.
// - While blink reset is set, all blink counters are held at zero.
// - Four bit-position enables gate interrupts of that bit in every port.
// - With gap disable set, repeated bursts follow with no idle gap.
// - Gap field code k gives an idle gap of (k+1) times 1.05 ms.
// - Single shot emits one burst; hardware clears it when the burst ends.
// - Auto repeat emits bursts with gaps until software clears it.
// - Load polarity 0 makes load active low, 1 active high.
// - Width code 0..3 shifts one to four bits per port.
// - Output goes highest port, highest enabled bit first, or port 0 bit 0 first when reversed.
// - Input arrives port 0 bit 0 first, or the opposite when reversed.
// - Shift clock period is the divider value in system clock cycles.
// - Divider 0 stops the shift clock; software never writes 1.
// - Sticky bits set when the shifted-in value meets its interrupt condition.
// - Sticky bits of disabled serial GPIOs read as zero.
// - Polarity 0 makes input 1 an interrupt, polarity 1 makes input 0 one.
// - Disabled ports have their serial GPIOs treated as disabled.
`include "serial_gpio_consts.svh"

module serial_gpio_shift_controller
  import serial_gpio_pkg::*;
#(
  parameter int BLINK_TICK_CYCLES = int'(`BLINK_TICK_CYCLES),
  parameter int GAP_STEP_CYCLES   = int'(`GAP_STEP_CYCLES)
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             sclk,
  output logic             sdata_out,
  input  wire logic        sdata_in,
  output logic             load_strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [`CFG_WIDTH-1:0] config_reg;
  logic [11:0]           divider;
  logic [31:0]           port_enable_vector;
  gpio_vector_t          irq_level_polarity;
  gpio_vector_t          input_data;
  gpio_vector_t          sticky;
  gpio_vector_t          output_value;
  logic [7:0]            output_mode;
  gpio_vector_t          shadow_in;
  logic                  phase_valid;
  logic                  phase_write;
  logic [7:0]            phase_addr;
  engine_state_t         state;
  logic [6:0]            bit_count;
  logic [11:0]           clk_count;
  logic [31:0]           gap_count;
  logic [31:0]           tick_count;
  logic [3:0]            blink_div;
  logic                  burst_toggle;

  logic [`CFG_WIDTH-1:0] next_config_reg;
  logic [11:0]           next_divider;
  logic [31:0]           next_port_enable_vector;
  gpio_vector_t          next_irq_level_polarity;
  gpio_vector_t          next_input_data;
  gpio_vector_t          next_sticky;
  gpio_vector_t          next_output_value;
  logic [7:0]            next_output_mode;
  gpio_vector_t          next_shadow_in;
  logic                  next_phase_valid;
  logic                  next_phase_write;
  logic [7:0]            next_phase_addr;
  logic                  next_hreadyout;
  logic [31:0]           next_hrdata;
  engine_state_t         next_state;
  logic [6:0]            next_bit_count;
  logic [11:0]           next_clk_count;
  logic [31:0]           next_gap_count;
  logic [31:0]           next_tick_count;
  logic [3:0]            next_blink_div;
  logic                  next_burst_toggle;
  logic                  next_sclk;
  logic                  next_sdata_out;
  logic                  next_load_strobe;

  logic                  take;
  logic                  wr_en;
  logic                  rd_cycle;
  logic [1:0]            rep;
  logic [3:0]            group;
  logic [1:0]            width_code;
  logic [1:0]            blink_a_select;
  logic [1:0]            blink_b_select;
  logic [3:0]            bit_position_irq_enable;
  logic                  blink_a;
  logic                  blink_b;
  logic                  clk_run;
  logic                  period_end;
  logic                  burst_done;
  logic                  sample;
  logic [6:0]            last_bit;
  logic [31:0]           gap_target;
  logic [31:0]           rd_mask;
  gpio_vector_t          gpio_on;
  gpio_vector_t          out_eff;
  gpio_vector_t          sticky_set;
  gpio_vector_t          sticky_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Stream position to replication index {bit, port}

  function automatic logic [6:0] map_position(input logic [6:0] idx, input logic [1:0] code, input logic flip);
    logic [6:0] last;
    logic [6:0] f;
    logic [6:0] port3;
    logic [6:0] rem3;
    logic [6:0] result;
    last   = {code, 5'h1F};
    f      = flip ? 7'(last - idx) : idx;
    port3  = 7'(f / 7'd3);
    rem3   = 7'(f - 7'(port3 * 7'd3));
    result = 7'h00;
    unique case (code)
      2'd0: result = {2'b00, f[4:0]};
      2'd1: result = {1'b0, f[0], f[5:1]};
      2'd2: result = {rem3[1:0], port3[4:0]};
      2'd3: result = {f[1:0], f[6:2]};
    endcase
    return result;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Field decode

  assign width_code              = config_reg[`CFG_WIDTH_LSB +: 2];
  assign blink_a_select          = config_reg[`CFG_BLINK_A_LSB +: 2];
  assign blink_b_select          = config_reg[`CFG_BLINK_B_LSB +: 2];
  assign bit_position_irq_enable = config_reg[`CFG_IRQ_EN_LSB +: 4];
  assign blink_a    = blink_div[blink_a_select];
  assign blink_b    = (blink_b_select == 2'd3) ? burst_toggle : blink_div[blink_b_select];
  assign clk_run    = divider >= 12'd2;
  assign period_end = clk_count == 12'(divider - 12'd1);
  assign last_bit   = {width_code, 5'h1F};
  assign burst_done = (state == STATE_LOAD) && period_end && clk_run;
  assign sample     = (state == STATE_SHIFT) && (clk_count == (divider >> 1));
  assign gap_target = 32'((32'(config_reg[`CFG_GAP_LSB +: 5]) + 32'd1) * 32'(GAP_STEP_CYCLES));

  ////////////////////////////////////////////////////////////////////////////
  // Per-GPIO logic

  for (genvar k = 0; k < 128; k++) begin : gen_gpio
    localparam int BITPOS = k / 32;
    localparam int PORT   = k % 32;
    assign gpio_on[k]    = port_enable_vector[PORT] & (2'(BITPOS) <= width_code);
    assign out_eff[k]    = output_value[k] & (~output_mode[2 * BITPOS] | blink_a)
                           & (~output_mode[2 * BITPOS + 1] | blink_b);
    assign sticky_set[k] = burst_done & bit_position_irq_enable[BITPOS] & gpio_on[k]
                           & (shadow_in[k] ^ irq_level_polarity[k]);
    assign sticky_clr[k] = wr_en & ({group, 4'h0} == `OFS_STICKY_INT) & (rep == 2'(BITPOS)) & hwdata[PORT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and registers

  assign take     = hsel & htrans[1] & hready;
  assign wr_en    = phase_valid & phase_write & hreadyout;
  assign rd_cycle = phase_valid & ~phase_write & ~hreadyout;
  assign rep      = phase_addr[3:2];
  assign group    = phase_addr[7:4];
  assign rd_mask  = gpio_on[{rep, 5'h00} +: 32];

  always_comb begin
    next_phase_valid        = take | (phase_valid & ~hreadyout);
    next_phase_write        = take ? hwrite : phase_write;
    next_phase_addr         = take ? haddr[7:0] : phase_addr;
    next_hreadyout          = ~(take & ~hwrite);
    next_hrdata             = hrdata;
    next_config_reg         = config_reg;
    next_divider            = divider;
    next_port_enable_vector = port_enable_vector;
    next_irq_level_polarity = irq_level_polarity;
    next_output_value       = output_value;
    next_output_mode        = output_mode;
    next_input_data         = burst_done ? shadow_in : input_data;
    next_sticky             = sticky_set | (sticky & ~sticky_clr);
    if (wr_en) begin
      if (phase_addr == `OFS_GENERAL_CONFIG) begin
        next_config_reg = hwdata[`CFG_WIDTH-1:0];
      end
      if (phase_addr == `OFS_SHIFT_CLOCK) begin
        next_divider = hwdata[11:0];
      end
      if (phase_addr == `OFS_PORT_ENABLE) begin
        next_port_enable_vector = hwdata;
      end
      if (phase_addr == `OFS_OUTPUT_MODE) begin
        next_output_mode = hwdata[7:0];
      end
      if ({group, 4'h0} == `OFS_INT_POLARITY) begin
        next_irq_level_polarity[{rep, 5'h00} +: 32] = hwdata;
      end
      if ({group, 4'h0} == `OFS_OUTPUT_VALUE) begin
        next_output_value[{rep, 5'h00} +: 32] = hwdata;
      end
    end
    // Set from a write wins over the end-of-burst clear
    next_config_reg[`CFG_SINGLE_SHOT] = (config_reg[`CFG_SINGLE_SHOT] & ~burst_done)
                                        | (wr_en && phase_addr == `OFS_GENERAL_CONFIG && hwdata[`CFG_SINGLE_SHOT]);
    if (rd_cycle) begin
      next_hrdata = `RST_WORD;
      if ({group, 4'h0} == `OFS_INPUT_DATA) begin
        next_hrdata = input_data[{rep, 5'h00} +: 32];
      end
      if ({group, 4'h0} == `OFS_INT_POLARITY) begin
        next_hrdata = irq_level_polarity[{rep, 5'h00} +: 32];
      end
      if ({group, 4'h0} == `OFS_STICKY_INT) begin
        next_hrdata = sticky[{rep, 5'h00} +: 32] & rd_mask;
      end
      if ({group, 4'h0} == `OFS_OUTPUT_VALUE) begin
        next_hrdata = output_value[{rep, 5'h00} +: 32];
      end
      if (phase_addr == `OFS_PORT_ENABLE) begin
        next_hrdata = port_enable_vector;
      end
      if (phase_addr == `OFS_GENERAL_CONFIG) begin
        next_hrdata = {10'h000, config_reg};
      end
      if (phase_addr == `OFS_SHIFT_CLOCK) begin
        next_hrdata = {20'h00000, divider};
      end
      if (phase_addr == `OFS_OUTPUT_MODE) begin
        next_hrdata = {24'h000000, output_mode};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      phase_valid        <= 1'b0;
      phase_write        <= 1'b0;
      phase_addr         <= 8'h00;
      hreadyout          <= 1'b1;
      hrdata             <= `RST_WORD;
      hresp              <= 1'b0;
      config_reg         <= `RST_CONFIG;
      divider            <= `RST_DIVIDER;
      port_enable_vector <= `RST_WORD;
      irq_level_polarity <= `RST_VECTOR;
      output_value       <= `RST_VECTOR;
      output_mode        <= 8'h00;
      input_data         <= `RST_VECTOR;
      sticky             <= `RST_VECTOR;
    end else begin
      phase_valid        <= next_phase_valid;
      phase_write        <= next_phase_write;
      phase_addr         <= next_phase_addr;
      hreadyout          <= next_hreadyout;
      hrdata             <= next_hrdata;
      hresp              <= 1'b0;
      config_reg         <= next_config_reg;
      divider            <= next_divider;
      port_enable_vector <= next_port_enable_vector;
      irq_level_polarity <= next_irq_level_polarity;
      output_value       <= next_output_value;
      output_mode        <= next_output_mode;
      input_data         <= next_input_data;
      sticky             <= next_sticky;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink generation

  always_comb begin
    next_tick_count   = (tick_count == 32'(BLINK_TICK_CYCLES - 1)) ? 32'h00000000 : 32'(tick_count + 32'd1);
    next_blink_div    = (tick_count == 32'(BLINK_TICK_CYCLES - 1)) ? 4'(blink_div + 4'd1) : blink_div;
    next_burst_toggle = burst_done ? ~burst_toggle : burst_toggle;
    if (config_reg[`CFG_BLINK_RESET]) begin
      next_tick_count   = 32'h00000000;
      next_blink_div    = 4'h0;
      next_burst_toggle = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tick_count   <= 32'h00000000;
      blink_div    <= 4'h0;
      burst_toggle <= 1'b0;
    end else begin
      tick_count   <= next_tick_count;
      blink_div    <= next_blink_div;
      burst_toggle <= next_burst_toggle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst engine

  always_comb begin
    next_state     = state;
    next_bit_count = bit_count;
    next_clk_count = clk_count;
    next_gap_count = gap_count;
    next_shadow_in = shadow_in;
    if (sample) begin
      next_shadow_in[map_position(bit_count, width_code, config_reg[`CFG_REVERSE_IN])] = sdata_in;
    end
    unique case (state)
      STATE_IDLE: begin
        if (clk_run && (config_reg[`CFG_SINGLE_SHOT] || config_reg[`CFG_AUTO_REPEAT])) begin
          next_state     = STATE_SHIFT;
          next_bit_count = 7'h00;
          next_clk_count = 12'h000;
        end
      end
      STATE_SHIFT: begin
        if (period_end) begin
          next_clk_count = 12'h000;
          if (bit_count == last_bit) begin
            next_state = STATE_LOAD;
          end else begin
            next_bit_count = 7'(bit_count + 7'd1);
          end
        end else begin
          next_clk_count = 12'(clk_count + 12'd1);
        end
      end
      STATE_LOAD: begin
        if (period_end) begin
          next_clk_count = 12'h000;
          next_bit_count = 7'h00;
          next_gap_count = 32'h00000000;
          if (config_reg[`CFG_AUTO_REPEAT] && config_reg[`CFG_GAP_DISABLE]) begin
            next_state = STATE_SHIFT;
          end else if (config_reg[`CFG_AUTO_REPEAT]) begin
            next_state = STATE_GAP;
          end else begin
            next_state = STATE_IDLE;
          end
        end else begin
          next_clk_count = 12'(clk_count + 12'd1);
        end
      end
      STATE_GAP: begin
        if (gap_count == 32'(gap_target - 32'd1)) begin
          next_state = STATE_IDLE;
        end else begin
          next_gap_count = 32'(gap_count + 32'd1);
        end
      end
    endcase
    if (!clk_run) begin
      next_state = STATE_IDLE;
    end
    next_sclk        = (next_state == STATE_SHIFT) && (next_clk_count >= (divider >> 1));
    next_sdata_out   = (next_state == STATE_SHIFT)
                       && out_eff[map_position(next_bit_count, width_code, ~config_reg[`CFG_REVERSE_OUT])];
    next_load_strobe = ~((next_state == STATE_LOAD) ^ config_reg[`CFG_LOAD_POLARITY]);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state       <= STATE_IDLE;
      bit_count   <= 7'h00;
      clk_count   <= 12'h000;
      gap_count   <= 32'h00000000;
      shadow_in   <= `RST_VECTOR;
      sclk        <= 1'b0;
      sdata_out   <= 1'b0;
      load_strobe <= 1'b1;
    end else begin
      state       <= next_state;
      bit_count   <= next_bit_count;
      clk_count   <= next_clk_count;
      gap_count   <= next_gap_count;
      shadow_in   <= next_shadow_in;
      sclk        <= next_sclk;
      sdata_out   <= next_sdata_out;
      load_strobe <= next_load_strobe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  single_clear_a: assert property (@(posedge clock) disable iff (reset)
    (burst_done && !(wr_en && phase_addr == `OFS_GENERAL_CONFIG)) |=> !config_reg[`CFG_SINGLE_SHOT])
    else $error("single shot not cleared after burst");

  load_idle_a: assert property (@(posedge clock) disable iff (reset)
    (state == STATE_IDLE && next_state == STATE_IDLE) |=> (load_strobe != $past(config_reg[`CFG_LOAD_POLARITY])))
    else $error("load strobe active outside a burst");

  clock_stop_a: assert property (@(posedge clock) disable iff (reset)
    (divider < 12'd2) |=> (!sclk && state == STATE_IDLE))
    else $error("shift clock runs with divider below two");

  sticky_mask_a: assert property (@(posedge clock) disable iff (reset)
    (rd_cycle && {group, 4'h0} == `OFS_STICKY_INT) |=> ((hrdata & ~$past(rd_mask)) == 32'h00000000))
    else $error("disabled gpio sticky bit reads as one");

  blink_hold_a: assert property (@(posedge clock) disable iff (reset)
    config_reg[`CFG_BLINK_RESET] |=> (blink_div == 4'h0 && tick_count == 32'h00000000))
    else $error("blink counters run during blink reset");

  gap_length_a: assert property (@(posedge clock) disable iff (reset)
    (state == STATE_LOAD && next_state == STATE_GAP) |=> (state == STATE_GAP) [*8])
    else $error("burst gap ended too early");

  no_gap_a: assert property (@(posedge clock) disable iff (reset)
    (burst_done && config_reg[`CFG_AUTO_REPEAT] && config_reg[`CFG_GAP_DISABLE]) |=> state == STATE_SHIFT)
    else $error("gap inserted while gap disabled");

  burst_toggle_a: assert property (@(posedge clock) disable iff (reset)
    (burst_done && !config_reg[`CFG_BLINK_RESET]) |=> (burst_toggle != $past(burst_toggle)))
    else $error("burst toggle did not flip");

  sticky_set_a: assert property (@(posedge clock) disable iff (reset)
    sticky_set[0] |=> sticky[0])
    else $error("sticky bit not set by input condition");

  auto_start_a: assert property (@(posedge clock) disable iff (reset)
    (state == STATE_IDLE && config_reg[`CFG_AUTO_REPEAT] && clk_run) |=> state == STATE_SHIFT)
    else $error("auto repeat did not start a burst");

endmodule

// file: verification/serial_gpio_chain_model.sv
// Behavioural model of the external shift register chain
module serial_gpio_chain_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        sclk,
  input  wire logic        sdata_out,
  input  wire logic        load_strobe,
  input  wire logic        load_polarity,
  input  wire logic [31:0] in_pattern,
  output logic             sdata_in,
  output logic [31:0]      out_latched,
  output logic [7:0]       load_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] shift;
  logic [5:0]  idx;
  logic        sclk_q;
  logic        load_q;
  logic        load_act;
  assign load_act = (load_strobe == load_polarity);
  assign sdata_in = in_pattern[idx[4:0]];
  always_ff @(posedge clock) begin
    if (reset) begin
      shift <= 32'h00000000;
      idx <= 6'h00;
      sclk_q <= 1'b0;
      load_q <= 1'b0;
      out_latched <= 32'h00000000;
      load_count <= 8'h00;
    end else begin
      sclk_q <= sclk;
      load_q <= load_act;
      // Capture on the rising shift clock, advance input on the falling one
      if (sclk && !sclk_q) shift <= {shift[30:0], sdata_out};
      if (!sclk && sclk_q) idx <= idx + 6'h01;
      if (load_act && !load_q) begin
        out_latched <= shift;
        load_count <= load_count + 8'h01;
        idx <= 6'h00;
      end
    end
  end
endmodule

// file: verification/test_serial_gpio_shift_controller.sv
// Register-level bench for the serial GPIO shift controller
module test_serial_gpio_shift_controller;
  import serial_gpio_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PAT = 32'h5A3CC3A5;
  localparam logic [31:0] VAL = 32'hC0FFEE15;
  logic clock, reset, hsel, hwrite, hreadyout, hresp, sclk, sdata_out, sdata_in, load_strobe, load_pol;
  logic [31:0] haddr, hwdata, hrdata, d, out_latched, vr, pr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  load_count, c;
  int bad_count, comparisons, k, cyc;
  serial_gpio_shift_controller #(.BLINK_TICK_CYCLES(8), .GAP_STEP_CYCLES(16)) u_serial_gpio_shift_controller (
    .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sclk(sclk), .sdata_out(sdata_out), .sdata_in(sdata_in), .load_strobe(load_strobe));
  serial_gpio_chain_model u_serial_gpio_chain_model (
    .clock(clock), .reset(reset), .sclk(sclk), .sdata_out(sdata_out), .load_strobe(load_strobe),
    .load_polarity(load_pol), .in_pattern(PAT), .sdata_in(sdata_in), .out_latched(out_latched),
    .load_count(load_count));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  // Sample the answer before the edge that ends the phase
  task automatic step(output logic [31:0] rd);
    int n;
    logic r;
    n = 0;
    do begin
      @(negedge clock);
      r = hreadyout;
      rd = hrdata;
      @(posedge clock);
      n++;
    end while (r !== 1'b1 && n < 100);
    if (r !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    step(rd);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    step(rd);
  endtask
  task automatic wait_burst();
    for (k = 0; k < 60; k++) begin
      bus(1'b0, 32'h000000A8, 32'h0, d);
      if (d[6] === 1'b0) break;
    end
    if (k == 60) begin
      bad_count++;
      wrap_up();
    end
  endtask
  // Cycles from one load strobe to the next
  task automatic load_period(output int cyc);
    logic [7:0] c0;
    c0 = load_count;
    for (cyc = 0; cyc < 400 && load_count == c0; cyc++) @(negedge clock);
    c0 = load_count;
    for (cyc = 0; cyc < 400 && load_count == c0; cyc++) @(negedge clock);
    if (cyc == 400) begin
      bad_count++;
      wrap_up();
    end
  endtask
  initial begin
    {hsel, hwrite, load_pol} = 3'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    bad_count = 0;
    comparisons = 0;
    vr = {<<{VAL}};
    pr = {<<{PAT}};
    reset = 1'b1;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    bus(1'b0, 32'h000000A8, 32'h0, d); check("config reset", 32'h0, d);
    bus(1'b0, 32'h000000AC, 32'h0, d); check("divider reset", 32'h0, d);
    bus(1'b0, 32'h000000B0, 32'h0, d); check("sticky reset", 32'h0, d);
    bus(1'b0, 32'h000000F0, 32'h0, d); check("unmapped", 32'h0, d);
    bus(1'b1, 32'h000000AC, 32'h2, d);
    bus(1'b0, 32'h000000AC, 32'h0, d); check("divider", 32'h2, d);
    bus(1'b1, 32'h000000C0, VAL, d);
    bus(1'b1, 32'h000000A4, 32'h0000FFFF, d);
    for (int rev = 0; rev < 2; rev++) begin
      bus(1'b1, 32'h000000A8, 32'h00002040 | (rev * 3), d);
      wait_burst();
      check("load count", rev + 1, {24'h0, load_count});
      check("output stream", rev ? vr : VAL, out_latched);
      bus(1'b0, 32'h00000000, 32'h0, d);
      check("input data", (rev ? pr : PAT) & 32'h0000FFFF, d & 32'h0000FFFF);
      if (rev == 0) begin
        bus(1'b0, 32'h000000B0, 32'h0, d); check("sticky set", PAT & 32'h0000FFFF, d);
        bus(1'b1, 32'h000000B0, 32'hFFFFFFFF, d);
        bus(1'b0, 32'h000000B0, 32'h0, d); check("sticky clear", 32'h0, d);
        bus(1'b0, 32'h000000B4, 32'h0, d); check("sticky bit1", 32'h0, d);
      end
    end
    // Burst of 64 cycles, load 2, gap 16, idle 1
    bus(1'b1, 32'h000000A8, 32'h00000020, d);
    load_period(cyc); check("gap period", 32'd83, cyc);
    bus(1'b1, 32'h000000A8, 32'h00001020, d);
    load_period(cyc); check("no gap period", 32'd66, cyc);
    bus(1'b1, 32'h000000A8, 32'h00000000, d);
    c = load_count;
    repeat (300) @(posedge clock);
    check("repeat stopped", {24'h0, 8'(c + 8'h01)}, {24'h0, load_count});
    bus(1'b1, 32'h000000D0, 32'h00000002, d);
    bus(1'b1, 32'h000000A8, 32'h00320000, d);
    for (int n = 0; n < 2; n++) begin
      bus(1'b1, 32'h000000A8, 32'h00300040, d);
      wait_burst();
      check("burst toggle", n ? VAL : 32'h0, out_latched);
    end
    bus(1'b1, 32'h000000AC, 32'h0, d);
    c = load_count;
    bus(1'b1, 32'h000000A8, 32'h00000040, d);
    repeat (100) @(posedge clock);
    bus(1'b0, 32'h000000A8, 32'h0, d); check("pending shot", 32'h00000040, d);
    check("no burst", {24'h0, c}, {24'h0, load_count});
    bus(1'b1, 32'h000000A8, 32'h00000010, d);
    repeat (3) @(posedge clock);
    @(negedge clock);
    check("load idle", 32'h0, {31'h0, load_strobe});
    wrap_up();
  end
endmodule
